// [src/orcc_top.sv]
// Output rail configuration bank: command port, target selection, clamp, ramp and readouts.
`timescale 1ns/1ps
module orcc_top (
	// Clock and reset.
	input wire logic clock_in,
	input wire logic resetn_in,
	// Command port.
	input wire logic cmd_start_in,
	input wire logic cmd_write_in,
	input wire logic [7:0] cmd_code_in,
	input wire logic byte_valid_in,
	input wire logic [7:0] byte_in,
	input wire logic byte_req_in,
	output logic [7:0] byte_out,
	output logic byte_valid_out,
	output logic cmd_busy_out,
	output logic cmd_unknown_out,
	// Operating inputs.
	input wire orcc_pkg::orcc_margin_t margin_sel_in,
	input wire logic [15:0] nominal_target_in,
	input wire logic [15:0] trim_in,
	input wire logic [4:0] vout_exponent_in,
	input wire logic [15:0] vin_meas_in,
	input wire logic [15:0] iout_raw_in,
	// Rail control outputs.
	output logic [15:0] rail_target_out,
	output logic [4:0] vout_exponent_out,
	output logic floor_warn_out,
	output logic conversion_on_out,
	output logic [15:0] load_line_slope_out,
	output logic [15:0] duty_cycle_ceiling_out,
	output logic [15:0] switching_rate_out,
	output orcc_pkg::orcc_phase_t phase_out,
	output logic [15:0] iout_report_out
);
	import orcc_pkg::*;

	// ************************************************************
	// Command port state machine.
	// ************************************************************
	typedef enum logic [4:0] {
		ORCC_IDLE = 5'h01,
		ORCC_WR_LO = 5'h02,
		ORCC_WR_HI = 5'h04,
		ORCC_RD_LO = 5'h08,
		ORCC_RD_HI = 5'h10
	} orcc_state_t;

	orcc_state_t state_q;
	logic [IDX_W:0] dec;
	logic [IDX_W-1:0] idx_q;
	logic known_q;
	logic [7:0] lo_q;
	logic wr_en;
	logic [15:0] wr_data;
	logic [15:0] rd_data;
	orcc_cfg_t cfg;

	assign dec = orcc_decode(cmd_code_in);
	// Unknown codes are walked through the byte sequence but never stored.
	assign wr_en = (state_q == ORCC_WR_HI) && byte_valid_in && known_q;
	assign wr_data = {byte_in, lo_q};

	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			state_q <= ORCC_IDLE;
		end else begin
			unique case (state_q)
				ORCC_IDLE: begin
					if (cmd_start_in) begin
						state_q <= cmd_write_in ? ORCC_WR_LO : ORCC_RD_LO;
					end
				end
				ORCC_WR_LO: begin
					if (byte_valid_in) begin
						state_q <= ORCC_WR_HI;
					end
				end
				ORCC_WR_HI: begin
					if (byte_valid_in) begin
						state_q <= ORCC_IDLE;
					end
				end
				ORCC_RD_LO: begin
					if (byte_req_in) begin
						state_q <= ORCC_RD_HI;
					end
				end
				ORCC_RD_HI: begin
					if (byte_req_in) begin
						state_q <= ORCC_IDLE;
					end
				end
				default: begin
					state_q <= ORCC_IDLE;
				end
			endcase
		end
	end

	// ************************************************************
	// Transaction capture.
	// ************************************************************
	// Captures the decoded slot at the start of a transaction.
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			idx_q <= IDX_MARGIN_UP;
			known_q <= 1'b0;
		end else if (state_q == ORCC_IDLE && cmd_start_in) begin
			idx_q <= dec[IDX_W-1:0];
			known_q <= dec[IDX_W];
		end
	end

	// ************************************************************
	// Write byte path.
	// ************************************************************
	// Low byte arrives first and waits for its partner.
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			lo_q <= 8'h00;
		end else if (state_q == ORCC_WR_LO && byte_valid_in) begin
			lo_q <= byte_in;
		end
	end

	// ************************************************************
	// Read byte path.
	// ************************************************************
	// Read bytes, low first, one per request.
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			byte_out <= 8'h00;
			byte_valid_out <= 1'b0;
		end else begin
			byte_valid_out <= 1'b0;
			if (state_q == ORCC_RD_LO && byte_req_in) begin
				byte_out <= known_q ? rd_data[7:0] : UNMAPPED_READ[7:0];
				byte_valid_out <= 1'b1;
			end else if (state_q == ORCC_RD_HI && byte_req_in) begin
				byte_out <= known_q ? rd_data[15:8] : UNMAPPED_READ[15:8];
				byte_valid_out <= 1'b1;
			end
		end
	end

	// ************************************************************
	// Status flags.
	// ************************************************************
	// Busy level and unknown-code pulse.
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			cmd_busy_out <= 1'b0;
			cmd_unknown_out <= 1'b0;
		end else begin
			cmd_unknown_out <= (state_q == ORCC_IDLE) && cmd_start_in && !dec[IDX_W];
			if (state_q == ORCC_IDLE) begin
				cmd_busy_out <= cmd_start_in;
			end else if ((state_q == ORCC_WR_HI && byte_valid_in) ||
					(state_q == ORCC_RD_HI && byte_req_in)) begin
				cmd_busy_out <= 1'b0;
			end
		end
	end

	// ************************************************************
	// Configuration storage.
	// ************************************************************
	orcc_regfile u_regfile (
		.clock_in(clock_in),
		.resetn_in(resetn_in),
		.wr_en_in(wr_en),
		.wr_idx_in(idx_q),
		.wr_data_in(wr_data),
		.rd_idx_in(idx_q),
		.rd_data_out(rd_data),
		.cfg_out(cfg)
	);

	// ************************************************************
	// Target selection and floor clamp.
	// ************************************************************
	logic [15:0] sel_target;
	logic signed [17:0] sum_target;
	logic [15:0] pos_target;
	logic below_floor;
	logic [15:0] eff_target;

	always_comb begin
		unique case (margin_sel_in)
			ORCC_SEL_UP: sel_target = cfg.margin_up_target;
			ORCC_SEL_DOWN: sel_target = cfg.margin_down_target;
			default: sel_target = nominal_target_in;
		endcase
	end

	// Trim is a signed mantissa on the same exponent as the target.
	assign sum_target = $signed({2'b00, sel_target}) + $signed({{2{trim_in[15]}}, trim_in});

	// Saturation keeps a large negative trim from wrapping to a high target.
	always_comb begin
		if (sum_target < 0) begin
			pos_target = 16'h0000;
		end else if (sum_target > 18'sh0FFFF) begin
			pos_target = 16'hFFFF;
		end else begin
			pos_target = sum_target[15:0];
		end
	end

	assign below_floor = pos_target < cfg.output_floor;
	assign eff_target = below_floor ? cfg.output_floor : pos_target;

	// ************************************************************
	// Floor warning.
	// ************************************************************
	// Warning level only; nothing here reaches a fault path.
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			floor_warn_out <= 1'b0;
		end else begin
			floor_warn_out <= below_floor;
		end
	end

	// ************************************************************
	// Slew-limited ramp toward the effective target.
	// ************************************************************
	logic [7:0] tick_q;
	logic tick;
	logic [15:0] step;
	logic [15:0] gap;

	assign tick = tick_q == RAMP_TICK_LAST;
	assign step = {5'h00, cfg.output_slew_rate[LIN_MANT_MSB:LIN_MANT_LSB]};
	assign gap = (rail_target_out > eff_target) ? (rail_target_out - eff_target) :
		(eff_target - rail_target_out);

	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			tick_q <= 8'h00;
		end else begin
			tick_q <= tick ? 8'h00 : tick_q + 8'h01;
		end
	end

	// ************************************************************
	// Rail step.
	// ************************************************************
	// A zero slew step moves the rail in one tick.
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rail_target_out <= 16'h0000;
		end else if (tick) begin
			if (step == 16'h0000 || gap <= step) begin
				rail_target_out <= eff_target;
			end else if (rail_target_out < eff_target) begin
				rail_target_out <= rail_target_out + step;
			end else begin
				rail_target_out <= rail_target_out - step;
			end
		end
	end

	// ************************************************************
	// Output-mode exponent.
	// ************************************************************
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			vout_exponent_out <= 5'h00;
		end else begin
			vout_exponent_out <= vout_exponent_in;
		end
	end

	// ************************************************************
	// Input voltage turn-on and turn-off.
	// ************************************************************
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			conversion_on_out <= 1'b0;
		end else if (!conversion_on_out) begin
			if (vin_meas_in >= cfg.input_turn_on_level) begin
				conversion_on_out <= 1'b1;
			end
		end else if (vin_meas_in <= cfg.input_turn_off_level) begin
			conversion_on_out <= 1'b0;
		end
	end

	// ************************************************************
	// Switching settings and interleave fields.
	// ************************************************************
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			load_line_slope_out <= WORD_RESET;
			duty_cycle_ceiling_out <= WORD_RESET;
			switching_rate_out <= WORD_RESET;
		end else begin
			load_line_slope_out <= cfg.load_line_slope;
			duty_cycle_ceiling_out <= cfg.duty_cycle_ceiling;
			switching_rate_out <= cfg.switching_rate;
		end
	end

	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			phase_out <= '0;
		end else begin
			phase_out.group_id <= cfg.phase_spread_setup[GROUP_MSB:GROUP_LSB];
			phase_out.unit_count <= cfg.phase_spread_setup[COUNT_MSB:COUNT_LSB];
			phase_out.rail_position <= cfg.phase_spread_setup[POS_MSB:POS_LSB];
		end
	end

	// ************************************************************
	// Output current reporting.
	// ************************************************************
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			iout_report_out <= 16'h0000;
		end else begin
			iout_report_out <= iout_raw_in + cfg.current_reading_offset;
		end
	end

endmodule

// [src/orcc_pkg.sv]
// Shared constants, command codes and carrier types for the rail configuration bank.
package orcc_pkg;

	// ************************************************************
	// Command codes and storage layout.
	// ************************************************************
	localparam logic [7:0] CMD_MARGIN_UP = 8'h25;
	localparam logic [7:0] CMD_MARGIN_DOWN = 8'h26;
	localparam logic [7:0] CMD_SLEW = 8'h27;
	localparam logic [7:0] CMD_LOAD_LINE = 8'h28;
	localparam logic [7:0] CMD_FLOOR = 8'h2B;
	localparam logic [7:0] CMD_DUTY = 8'h32;
	localparam logic [7:0] CMD_SW_RATE = 8'h33;
	localparam logic [7:0] CMD_VIN_ON = 8'h35;
	localparam logic [7:0] CMD_VIN_OFF = 8'h36;
	localparam logic [7:0] CMD_PHASE = 8'h37;
	localparam logic [7:0] CMD_IOUT_OFS = 8'h39;

	localparam int NUM_WORDS = 11;
	localparam int IDX_W = 4;
	localparam logic [IDX_W-1:0] IDX_MARGIN_UP = 4'h0;
	localparam logic [IDX_W-1:0] IDX_MARGIN_DOWN = 4'h1;
	localparam logic [IDX_W-1:0] IDX_SLEW = 4'h2;
	localparam logic [IDX_W-1:0] IDX_LOAD_LINE = 4'h3;
	localparam logic [IDX_W-1:0] IDX_FLOOR = 4'h4;
	localparam logic [IDX_W-1:0] IDX_DUTY = 4'h5;
	localparam logic [IDX_W-1:0] IDX_SW_RATE = 4'h6;
	localparam logic [IDX_W-1:0] IDX_VIN_ON = 4'h7;
	localparam logic [IDX_W-1:0] IDX_VIN_OFF = 4'h8;
	localparam logic [IDX_W-1:0] IDX_PHASE = 4'h9;
	localparam logic [IDX_W-1:0] IDX_IOUT_OFS = 4'hA;

	localparam logic [15:0] WORD_RESET = 16'h0000;
	localparam logic [15:0] UNMAPPED_READ = 16'h0000;

	// ************************************************************
	// Field positions.
	// ************************************************************
	localparam int GROUP_MSB = 11;
	localparam int GROUP_LSB = 8;
	localparam int COUNT_MSB = 7;
	localparam int COUNT_LSB = 4;
	localparam int POS_MSB = 3;
	localparam int POS_LSB = 0;
	localparam int LIN_MANT_MSB = 10;
	localparam int LIN_MANT_LSB = 0;

	// ************************************************************
	// Timing.
	// ************************************************************
	localparam int CLOCK_MHZ = 200;
	localparam int RAMP_TICK_NS = 1000;
	localparam int RAMP_TICK_CYC = (RAMP_TICK_NS * CLOCK_MHZ) / 1000;
	localparam logic [7:0] RAMP_TICK_LAST = 8'(RAMP_TICK_CYC - 1);

	// ************************************************************
	// Types.
	// ************************************************************
	typedef enum logic [1:0] {
		ORCC_SEL_NOMINAL = 2'h0,
		ORCC_SEL_UP = 2'h1,
		ORCC_SEL_DOWN = 2'h2
	} orcc_margin_t;

	typedef struct packed {
		logic [15:0] margin_up_target;
		logic [15:0] margin_down_target;
		logic [15:0] output_slew_rate;
		logic [15:0] load_line_slope;
		logic [15:0] output_floor;
		logic [15:0] duty_cycle_ceiling;
		logic [15:0] switching_rate;
		logic [15:0] input_turn_on_level;
		logic [15:0] input_turn_off_level;
		logic [15:0] phase_spread_setup;
		logic [15:0] current_reading_offset;
	} orcc_cfg_t;

	typedef struct packed {
		logic [3:0] group_id;
		logic [3:0] unit_count;
		logic [3:0] rail_position;
	} orcc_phase_t;

	// Maps a command code to its storage slot; valid is low for unmapped codes.
	function automatic logic [IDX_W:0] orcc_decode(input logic [7:0] code);
		logic [IDX_W:0] r;
		r = {1'b0, IDX_MARGIN_UP};
		case (code)
			CMD_MARGIN_UP: r = {1'b1, IDX_MARGIN_UP};
			CMD_MARGIN_DOWN: r = {1'b1, IDX_MARGIN_DOWN};
			CMD_SLEW: r = {1'b1, IDX_SLEW};
			CMD_LOAD_LINE: r = {1'b1, IDX_LOAD_LINE};
			CMD_FLOOR: r = {1'b1, IDX_FLOOR};
			CMD_DUTY: r = {1'b1, IDX_DUTY};
			CMD_SW_RATE: r = {1'b1, IDX_SW_RATE};
			CMD_VIN_ON: r = {1'b1, IDX_VIN_ON};
			CMD_VIN_OFF: r = {1'b1, IDX_VIN_OFF};
			CMD_PHASE: r = {1'b1, IDX_PHASE};
			CMD_IOUT_OFS: r = {1'b1, IDX_IOUT_OFS};
			default: r = {1'b0, IDX_MARGIN_UP};
		endcase
		return r;
	endfunction

endpackage

// [src/orcc_regfile.sv]
// Word storage for the configuration bank with a registered read port.
`timescale 1ns/1ps
module orcc_regfile (
	// Clock and reset.
	input wire logic clock_in,
	input wire logic resetn_in,
	// Write port.
	input wire logic wr_en_in,
	input wire logic [orcc_pkg::IDX_W-1:0] wr_idx_in,
	input wire logic [15:0] wr_data_in,
	// Read port.
	input wire logic [orcc_pkg::IDX_W-1:0] rd_idx_in,
	output logic [15:0] rd_data_out,
	// Whole bank.
	output orcc_pkg::orcc_cfg_t cfg_out
);
	import orcc_pkg::*;

	logic [15:0] mem_q [0:NUM_WORDS-1];

	// ************************************************************
	// Storage.
	// ************************************************************
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			for (int i = 0; i < NUM_WORDS; i++) begin
				mem_q[i] <= WORD_RESET;
			end
		end else if (wr_en_in) begin
			mem_q[wr_idx_in] <= wr_data_in;
		end
	end

	// ************************************************************
	// Registered read.
	// ************************************************************
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rd_data_out <= WORD_RESET;
		end else if (32'(rd_idx_in) < NUM_WORDS) begin
			rd_data_out <= mem_q[rd_idx_in];
		end else begin
			rd_data_out <= UNMAPPED_READ;
		end
	end

	assign cfg_out = '{
		margin_up_target: mem_q[IDX_MARGIN_UP],
		margin_down_target: mem_q[IDX_MARGIN_DOWN],
		output_slew_rate: mem_q[IDX_SLEW],
		load_line_slope: mem_q[IDX_LOAD_LINE],
		output_floor: mem_q[IDX_FLOOR],
		duty_cycle_ceiling: mem_q[IDX_DUTY],
		switching_rate: mem_q[IDX_SW_RATE],
		input_turn_on_level: mem_q[IDX_VIN_ON],
		input_turn_off_level: mem_q[IDX_VIN_OFF],
		phase_spread_setup: mem_q[IDX_PHASE],
		current_reading_offset: mem_q[IDX_IOUT_OFS]
	};

endmodule

// [bench/orcc_top_monitor.sv]
// Port checker for the rail configuration bank.
`timescale 1ns/1ps
module orcc_top_monitor (
	// Clock and reset.
	input wire logic clock_in,
	input wire logic resetn_in,
	// Command port.
	input wire logic cmd_start_in,
	input wire logic byte_valid_in,
	input wire logic byte_req_in,
	input wire logic byte_valid_out,
	input wire logic cmd_busy_out,
	input wire logic cmd_unknown_out,
	// Rail side.
	input wire logic [4:0] vout_exponent_in,
	input wire logic [4:0] vout_exponent_out,
	input wire logic [15:0] rail_target_out,
	input wire logic [15:0] load_line_slope_out,
	input wire logic [15:0] duty_cycle_ceiling_out,
	input wire logic [15:0] switching_rate_out
);
	default clocking @(posedge clock_in); endclocking
	default disable iff (!resetn_in);
	int gap_q;
	logic seen_q;
	// ****
	// Counts cycles between rail steps.
	// ****
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			gap_q <= 0;
			seen_q <= 1'b0;
		end else if ($changed(rail_target_out) && $past(resetn_in)) begin
			gap_q <= 0;
			seen_q <= 1'b1;
		end else begin
			gap_q <= gap_q + 1;
		end
	end
	sequence s_start_idle;
		cmd_start_in && !cmd_busy_out;
	endsequence
	sequence s_copy_moved;
		$changed(load_line_slope_out) || $changed(duty_cycle_ceiling_out)
			|| $changed(switching_rate_out);
	endsequence
	a_start_sets_busy: assert property (s_start_idle |=> cmd_busy_out)
		else $error("busy did not follow an accepted start");
	a_busy_has_start: assert property ($rose(cmd_busy_out) |-> $past(cmd_start_in))
		else $error("busy rose without a start");
	a_unknown_cause: assert property (cmd_unknown_out |-> $past(cmd_start_in))
		else $error("unknown code flag without a start");
	a_unknown_single: assert property (cmd_unknown_out |=> !cmd_unknown_out)
		else $error("unknown code flag longer than one cycle");
	a_byte_answer: assert property (byte_valid_out |-> $past(byte_req_in))
		else $error("read byte without a request");
	a_exp_copy: assert property ($past(resetn_in) |->
		vout_exponent_out == $past(vout_exponent_in))
		else $error("exponent copy wrong");
	a_rail_tick_step: assert property ($changed(rail_target_out) && $past(resetn_in)
		&& seen_q |-> (gap_q + 1) % orcc_pkg::RAMP_TICK_CYC == 0)
		else $error("rail moved off the ramp tick");
	a_copy_after_write: assert property (s_copy_moved and $past(resetn_in) |->
		$past(byte_valid_in) || $past(byte_valid_in, 2))
		else $error("setting copy moved without a write");
endmodule
bind orcc_top orcc_top_monitor u_mon (.clock_in(clock_in), .resetn_in(resetn_in),
	.cmd_start_in(cmd_start_in), .byte_valid_in(byte_valid_in),
	.byte_req_in(byte_req_in), .byte_valid_out(byte_valid_out),
	.cmd_busy_out(cmd_busy_out), .cmd_unknown_out(cmd_unknown_out),
	.vout_exponent_in(vout_exponent_in), .vout_exponent_out(vout_exponent_out),
	.rail_target_out(rail_target_out), .load_line_slope_out(load_line_slope_out),
	.duty_cycle_ceiling_out(duty_cycle_ceiling_out),
	.switching_rate_out(switching_rate_out));

// [bench/orcc_host.sv]
// Host model that moves whole words through the command port.
`timescale 1ns/1ps
module orcc_host (
	// Clock.
	input wire logic clock_in,
	// Command port.
	output logic cmd_start_out,
	output logic cmd_write_out,
	output logic [7:0] cmd_code_out,
	output logic byte_valid_out,
	output logic [7:0] byte_out,
	output logic byte_req_out,
	input wire logic [7:0] byte_in,
	input wire logic byte_valid_in,
	input wire logic cmd_unknown_in
);
	logic [7:0] got[$];
	int unknown_count = 0;
	initial begin
		cmd_start_out = 1'b0;
		cmd_write_out = 1'b0;
		cmd_code_out = 8'h00;
		byte_valid_out = 1'b0;
		byte_out = 8'h00;
		byte_req_out = 1'b0;
	end
	always @(negedge clock_in) begin
		if (byte_valid_in === 1'b1) begin
			got.push_back(byte_in);
		end
		if (cmd_unknown_in === 1'b1) begin
			unknown_count++;
		end
	end
	// ****
	// Word transfers, low byte first.
	// ****
	task automatic write_word(input logic [7:0] code, input logic [15:0] data);
		@(posedge clock_in);
		cmd_start_out <= 1'b1;
		cmd_write_out <= 1'b1;
		cmd_code_out <= code;
		@(posedge clock_in);
		cmd_start_out <= 1'b0;
		byte_valid_out <= 1'b1;
		byte_out <= data[7:0];
		@(posedge clock_in);
		byte_out <= data[15:8];
		@(posedge clock_in);
		byte_valid_out <= 1'b0;
		byte_out <= ~data[15:8];
	endtask
	task automatic read_word(input logic [7:0] code, output logic [15:0] data,
		output bit ok);
		int n;
		got.delete();
		@(posedge clock_in);
		cmd_start_out <= 1'b1;
		cmd_write_out <= 1'b0;
		cmd_code_out <= code;
		@(posedge clock_in);
		cmd_start_out <= 1'b0;
		@(posedge clock_in);
		byte_req_out <= 1'b1;
		@(posedge clock_in);
		@(posedge clock_in);
		byte_req_out <= 1'b0;
		n = 0;
		while (got.size() < 2 && n < 8) begin
			@(posedge clock_in);
			n++;
		end
		ok = got.size() == 2;
		data = ok ? {got[1], got[0]} : 16'h0000;
	endtask
endmodule

// [bench/tb_top.sv]
// Self-checking bench for the rail configuration bank.
`timescale 1ns/1ps
module tb_top;
	import orcc_pkg::*;
	logic clock_in = 1'b0;
	logic resetn_in = 1'b0;
	logic cmd_start_in, cmd_write_in, byte_valid_in, byte_req_in;
	logic [7:0] cmd_code_in, byte_in, byte_out;
	logic byte_valid_out, cmd_busy_out, cmd_unknown_out, floor_warn_out, conversion_on_out;
	orcc_margin_t margin_sel_in = ORCC_SEL_NOMINAL;
	logic [15:0] nominal_target_in = 16'h0000;
	logic [15:0] trim_in = 16'h0000;
	logic [4:0] vout_exponent_in = 5'h00;
	logic [4:0] vout_exponent_out;
	logic [15:0] vin_meas_in = 16'h0000;
	logic [15:0] iout_raw_in = 16'h0000;
	logic [15:0] rail_target_out, load_line_slope_out, duty_cycle_ceiling_out;
	logic [15:0] switching_rate_out, iout_report_out;
	orcc_phase_t phase_out;
	int bad_count = 0;
	int comparisons = 0;
	int regs[11];
	logic [15:0] lfsr_q = 16'h28B3;
	logic [7:0] codes[11] = '{CMD_MARGIN_UP, CMD_MARGIN_DOWN, CMD_SLEW, CMD_LOAD_LINE,
		CMD_FLOOR, CMD_DUTY, CMD_SW_RATE, CMD_VIN_ON, CMD_VIN_OFF, CMD_PHASE, CMD_IOUT_OFS};
	int cases[7][3] = '{'{1, 0, 0}, '{2, 0, 0}, '{0, 16'h2000, -256}, '{0, 16'h0F00, 256},
		'{1, 0, -16'h4000}, '{0, 16'hFF00, 16'h0200}, '{3, 16'h2200, 0}};
	always #2.5 clock_in = ~clock_in;
	orcc_top DUT (.clock_in(clock_in), .resetn_in(resetn_in), .cmd_start_in(cmd_start_in),
		.cmd_write_in(cmd_write_in), .cmd_code_in(cmd_code_in), .byte_valid_in(byte_valid_in),
		.byte_in(byte_in), .byte_req_in(byte_req_in), .byte_out(byte_out),
		.byte_valid_out(byte_valid_out), .cmd_busy_out(cmd_busy_out),
		.cmd_unknown_out(cmd_unknown_out), .margin_sel_in(margin_sel_in),
		.nominal_target_in(nominal_target_in), .trim_in(trim_in),
		.vout_exponent_in(vout_exponent_in), .vin_meas_in(vin_meas_in),
		.iout_raw_in(iout_raw_in), .rail_target_out(rail_target_out),
		.vout_exponent_out(vout_exponent_out), .floor_warn_out(floor_warn_out),
		.conversion_on_out(conversion_on_out), .load_line_slope_out(load_line_slope_out),
		.duty_cycle_ceiling_out(duty_cycle_ceiling_out),
		.switching_rate_out(switching_rate_out), .phase_out(phase_out),
		.iout_report_out(iout_report_out));
	orcc_host host (.clock_in(clock_in), .cmd_start_out(cmd_start_in),
		.cmd_write_out(cmd_write_in), .cmd_code_out(cmd_code_in),
		.byte_valid_out(byte_valid_in), .byte_out(byte_in), .byte_req_out(byte_req_in),
		.byte_in(byte_out), .byte_valid_in(byte_valid_out), .cmd_unknown_in(cmd_unknown_out));
	// ****
	// Shared tasks.
	// ****
	function automatic logic [15:0] lfsr(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction
	task automatic chk_word(input string name, input int exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp[15:0]) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", name, exp[15:0], got);
		end
	endtask
	task automatic chk_flag(input string name, input bit exp, input logic got);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value %s expected %b seen %b", name, exp, got);
		end
	endtask
	task automatic end_of_test();
		$display("comparisons %0d bad_count %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge clock_in);
		@(negedge clock_in);
	endtask
	task automatic put(input int i, input int v);
		regs[i] = v & 16'hFFFF;
		host.write_word(codes[i], v[15:0]);
	endtask
	task automatic check_reg(input logic [7:0] code, input int exp);
		logic [15:0] d;
		bit ok;
		host.read_word(code, d, ok);
		chk_flag("read answered", 1'b1, ok);
		chk_word("read word", exp, d);
	endtask
	task automatic rail_case(input int sel, input int nom, input int trim);
		int t;
		t = (sel == 1 ? regs[0] : (sel == 2 ? regs[1] : nom)) + trim;
		t = t < 0 ? 0 : (t > 65535 ? 65535 : t);
		@(posedge clock_in);
		margin_sel_in <= orcc_margin_t'(sel[1:0]);
		nominal_target_in <= nom[15:0];
		trim_in <= trim[15:0];
		settle(205);
		chk_flag("floor warning", t < regs[4], floor_warn_out);
		chk_word("rail target", t < regs[4] ? regs[4] : t, rail_target_out);
	endtask
	initial begin
		repeat (100000) @(posedge clock_in);
		bad_count++;
		end_of_test();
	end
	// ****
	// Main sequence.
	// ****
	initial begin
		int n;
		bit conv;
		static int vins[7] = '{0, 99, 100, 51, 50, 99, 100};
		repeat (8) @(posedge clock_in);
		resetn_in <= 1'b1;
		for (int i = 0; i < 11; i++) begin
			check_reg(codes[i], 0);
			lfsr_q = lfsr(lfsr_q);
			put(i, lfsr_q);
			check_reg(codes[i], regs[i]);
		end
		settle(1);
		chk_word("slope copy", regs[3], load_line_slope_out);
		chk_word("duty copy", regs[5], duty_cycle_ceiling_out);
		chk_word("rate copy", regs[6], switching_rate_out);
		check_reg(8'h30, 0);
		host.write_word(8'h29, 16'hFFFF);
		chk_word("unknown count", 2, host.unknown_count[15:0]);
		put(9, 16'h0A30);
		settle(1);
		chk_word("group", 16'hA, phase_out.group_id);
		chk_word("count", 16'h3, phase_out.unit_count);
		chk_word("position", 16'h0, phase_out.rail_position);
		put(9, 16'h05C7);
		settle(1);
		chk_word("phase", 16'h05C7, phase_out);
		put(2, 0);
		put(4, 16'h1000);
		put(0, 16'h3000);
		put(1, 16'h0800);
		for (int i = 0; i < 7; i++) begin
			rail_case(cases[i][0], cases[i][1], cases[i][2]);
		end
		put(2, 16);
		@(posedge clock_in);
		nominal_target_in <= 16'h2100;
		n = 0;
		while (rail_target_out === 16'h2200 && n < 250) begin
			@(negedge clock_in);
			n++;
		end
		if (n >= 250) begin
			bad_count++;
			end_of_test();
		end
		chk_word("first ramp step", 16'h21F0, rail_target_out);
		settle(200);
		chk_word("second ramp step", 16'h21E0, rail_target_out);
		put(8, 50);
		put(7, 100);
		conv = 1'b0;
		for (int i = 0; i < 7; i++) begin
			@(posedge clock_in);
			vin_meas_in <= vins[i][15:0];
			conv = conv ? vins[i] > 50 : vins[i] >= 100;
			settle(3);
			chk_flag("conversion", conv, conversion_on_out);
		end
		for (int i = 0; i < 5; i++) begin
			lfsr_q = lfsr(lfsr_q);
			@(posedge clock_in);
			iout_raw_in <= i == 0 ? 16'hFFFF : lfsr_q;
			vout_exponent_in <= lfsr_q[4:0];
			settle(2);
			chk_word("current", ((i == 0 ? 65535 : lfsr_q) + regs[10]), iout_report_out);
			chk_word("exponent", lfsr_q[4:0], vout_exponent_out);
		end
		end_of_test();
	end
endmodule
